// ==== rtl/potc_consts.svh ====
// Register map, field positions and reset values of the pad output and tristate cell
`ifndef POTC_CONSTS_SVH
`define POTC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define POTC_ADDR_W 12
`define POTC_CTRL_ADDR 12'h000
`define POTC_STAT_ADDR 12'h004

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define POTC_CTRL_W 4
`define POTC_CTRL_RST 4'h0
`define POTC_CTRL_DRV_LSB 0
`define POTC_CTRL_DRV_MSB 1
`define POTC_CTRL_HIZ_LSB 2
`define POTC_CTRL_HIZ_MSB 3

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define POTC_STAT_W 8
`define POTC_STAT_PAD_O 0
`define POTC_STAT_PAD_OE 1
`define POTC_STAT_DRV_A 2
`define POTC_STAT_DRV_B 3
`define POTC_STAT_HIZ_A 4
`define POTC_STAT_HIZ_B 5
`define POTC_STAT_DRV_LAST_B 6
`define POTC_STAT_HIZ_LAST_B 7

// ----------------------------------------------------------------------
// Misc
// ----------------------------------------------------------------------
`define POTC_DRV_IDX 0
`define POTC_HIZ_IDX 1
`define POTC_NUM_PATHS 2
`define POTC_RDATA_RST 32'h0000_0000

`endif

// ==== rtl/potc_pkg.sv ====
// Types shared by the pad output and tristate cell
package potc_pkg;

  // ----------------------------------------------------------------------
  // Path selection for the drive value and the high-impedance request
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    POTC_PATH_DIRECT,
    POTC_PATH_LATCH,
    POTC_PATH_SDR,
    POTC_PATH_DDR
  } potc_path_t;

endpackage : potc_pkg

// ==== rtl/potc_pad_cell.sv ====
// Pad output and tristate cell with APB control and status registers
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "potc_consts.svh"

// Behaviour
// - Direct and latched drive paths beside register
// - Drive register loads only when enabled
// - Synchronous clear loads value at edge
// - Asynchronous clear forces pad without edge
// - Chip-wide init forces registers to value
// - DDR register a captures on clock a
// - DDR register b captures on clock b
// - One enable gates both DDR registers
// - DDR sync clear: each register at its own clock edge
// - Direct hiz request floats or drives pad
// - Hiz request selectable through latch too
// - Chip-wide float overrides local hiz request
// - Hiz register loads only when enabled
// - Registered hiz state reaches pad after edge
// - Asynchronous hiz clear floats or drives immediately
// - High request floats; sync clear loads HIZ_SR_SET
// - DDR hiz pair shares enable, latest wins
module potc_pad_cell
  import potc_pkg::*;
#(
  parameter logic DRV_SR_SET = 1'b0,
  parameter logic DRV_SR_ASYNC = 1'b0,
  parameter logic HIZ_SR_SET = 1'b1,
  parameter logic HIZ_SR_ASYNC = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`POTC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_clk_a,
  input wire logic drive_clk_b,
  input wire logic out_val,
  input wire logic ddr_val_a,
  input wire logic ddr_val_b,
  input wire logic drive_latch_gate,
  input wire logic drive_reg_en,
  input wire logic hiz_req,
  input wire logic hiz_req_a,
  input wire logic hiz_req_b,
  input wire logic hiz_latch_gate,
  input wire logic hiz_reg_en,
  input wire logic flop_preset_clear,
  input wire logic chip_wide_init,
  input wire logic chip_wide_float,
  output logic pad_o,
  output logic pad_oe
);

  // ----------------------------------------------------------------------
  // Control register and APB slave
  // ----------------------------------------------------------------------
  logic [`POTC_CTRL_W-1:0] ctrl;
  logic [`POTC_STAT_W-1:0] status;
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  potc_path_t drv_mode;
  potc_path_t hiz_mode;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;
  assign addr_ok = (paddr == `POTC_CTRL_ADDR) || (paddr == `POTC_STAT_ADDR);
  assign drv_mode = potc_path_t'(ctrl[`POTC_CTRL_DRV_MSB:`POTC_CTRL_DRV_LSB]);
  assign hiz_mode = potc_path_t'(ctrl[`POTC_CTRL_HIZ_MSB:`POTC_CTRL_HIZ_LSB]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `POTC_CTRL_RST;
    end else if (apb_write && (paddr == `POTC_CTRL_ADDR)) begin
      ctrl <= pwdata[`POTC_CTRL_W-1:0];
    end
  end

  // Zero wait states: pready rises for the access phase only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `POTC_RDATA_RST;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      if (apb_setup && !pwrite && (paddr == `POTC_CTRL_ADDR)) begin
        prdata <= {{(32-`POTC_CTRL_W){1'b0}}, ctrl};
      end else if (apb_setup && !pwrite && (paddr == `POTC_STAT_ADDR)) begin
        prdata <= {{(32-`POTC_STAT_W){1'b0}}, status};
      end else begin
        prdata <= `POTC_RDATA_RST;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output clock edge detection
  // ----------------------------------------------------------------------
  // The output clocks are sampled levels; each phase must last a pclk period.
  logic clk_a_q;
  logic clk_b_q;
  logic rise_a;
  logic rise_b;
  logic edges_primed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_a_q <= 1'b0;
      clk_b_q <= 1'b0;
      edges_primed <= 1'b0;
    end else begin
      clk_a_q <= drive_clk_a;
      clk_b_q <= drive_clk_b;
      edges_primed <= 1'b1;
    end
  end

  // Idle level of each clock pin is unknown at reset: the first sample only
  // primes the history, else a clock parked high fakes an edge
  assign rise_a = edges_primed && drive_clk_a && !clk_a_q;
  assign rise_b = edges_primed && drive_clk_b && !clk_b_q;

  // ----------------------------------------------------------------------
  // Drive path and hiz path, one generate entry each
  // ----------------------------------------------------------------------
  logic sr_set [`POTC_NUM_PATHS];
  logic sr_async [`POTC_NUM_PATHS];
  logic reg_en [`POTC_NUM_PATHS];
  logic gate [`POTC_NUM_PATHS];
  logic d_single [`POTC_NUM_PATHS];
  logic d_a [`POTC_NUM_PATHS];
  logic d_b [`POTC_NUM_PATHS];
  potc_path_t mode [`POTC_NUM_PATHS];
  logic lat_q [`POTC_NUM_PATHS];
  logic reg_a [`POTC_NUM_PATHS];
  logic reg_b [`POTC_NUM_PATHS];
  logic last_b [`POTC_NUM_PATHS];
  logic sel [`POTC_NUM_PATHS];

  assign sr_set[`POTC_DRV_IDX] = DRV_SR_SET;
  assign sr_async[`POTC_DRV_IDX] = DRV_SR_ASYNC;
  assign sr_set[`POTC_HIZ_IDX] = HIZ_SR_SET;
  assign sr_async[`POTC_HIZ_IDX] = HIZ_SR_ASYNC;
  assign reg_en[`POTC_DRV_IDX] = drive_reg_en;
  assign reg_en[`POTC_HIZ_IDX] = hiz_reg_en;
  assign gate[`POTC_DRV_IDX] = drive_latch_gate;
  assign gate[`POTC_HIZ_IDX] = hiz_latch_gate;
  assign d_single[`POTC_DRV_IDX] = out_val;
  assign d_single[`POTC_HIZ_IDX] = hiz_req;
  assign d_a[`POTC_DRV_IDX] = (drv_mode == POTC_PATH_DDR) ? ddr_val_a : out_val;
  assign d_a[`POTC_HIZ_IDX] = (hiz_mode == POTC_PATH_DDR) ? hiz_req_a : hiz_req;
  assign d_b[`POTC_DRV_IDX] = ddr_val_b;
  assign d_b[`POTC_HIZ_IDX] = hiz_req_b;
  assign mode[`POTC_DRV_IDX] = drv_mode;
  assign mode[`POTC_HIZ_IDX] = hiz_mode;

  genvar g;
  generate
    for (g = 0; g < `POTC_NUM_PATHS; g++) begin : g_path
      logic sync_clr;
      logic async_clr;

      assign sync_clr = flop_preset_clear && !sr_async[g];
      assign async_clr = flop_preset_clear && sr_async[g];

      // Transparent latch modelled as a flop that follows while the gate is open
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lat_q[g] <= 1'b0;
        end else if (gate[g]) begin
          lat_q[g] <= d_single[g];
        end
      end

      // Register a: single-rate register, or DDR register on clock a
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          reg_a[g] <= 1'b0;
        end else if (chip_wide_init) begin
          reg_a[g] <= sr_set[g];
        end else if (async_clr) begin
          reg_a[g] <= sr_set[g];
        end else if (rise_a && sync_clr) begin
          reg_a[g] <= sr_set[g];
        end else if (rise_a && reg_en[g]) begin
          reg_a[g] <= d_a[g];
        end
      end

      // Register b: DDR register on clock b, sharing the same enable
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          reg_b[g] <= 1'b0;
        end else if (chip_wide_init) begin
          reg_b[g] <= sr_set[g];
        end else if (async_clr) begin
          reg_b[g] <= sr_set[g];
        end else if (rise_b && sync_clr) begin
          reg_b[g] <= sr_set[g];
        end else if (rise_b && reg_en[g]) begin
          reg_b[g] <= d_b[g];
        end
      end

      // Remembers which clock rose last; clock a wins a tie, which
      // cannot happen when clock b is the inverse of clock a
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          last_b[g] <= 1'b0;
        end else if (rise_a) begin
          last_b[g] <= 1'b0;
        end else if (rise_b) begin
          last_b[g] <= 1'b1;
        end
      end

      always_comb begin
        unique case (mode[g])
          POTC_PATH_DIRECT: sel[g] = d_single[g];
          POTC_PATH_LATCH: sel[g] = lat_q[g];
          POTC_PATH_SDR: sel[g] = reg_a[g];
          POTC_PATH_DDR: sel[g] = last_b[g] ? reg_b[g] : reg_a[g];
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Pad outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_o <= 1'b0;
      pad_oe <= 1'b0;
    end else begin
      pad_o <= sel[`POTC_DRV_IDX];
      pad_oe <= !sel[`POTC_HIZ_IDX] && !chip_wide_float;
    end
  end

  always_comb begin
    status = '0;
    status[`POTC_STAT_PAD_O] = pad_o;
    status[`POTC_STAT_PAD_OE] = pad_oe;
    status[`POTC_STAT_DRV_A] = reg_a[`POTC_DRV_IDX];
    status[`POTC_STAT_DRV_B] = reg_b[`POTC_DRV_IDX];
    status[`POTC_STAT_HIZ_A] = reg_a[`POTC_HIZ_IDX];
    status[`POTC_STAT_HIZ_B] = reg_b[`POTC_HIZ_IDX];
    status[`POTC_STAT_DRV_LAST_B] = last_b[`POTC_DRV_IDX];
    status[`POTC_STAT_HIZ_LAST_B] = last_b[`POTC_HIZ_IDX];
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_direct_drive: assert property (
    (drv_mode == POTC_PATH_DIRECT) |=> (pad_o == $past(out_val)))
    else $error("direct path does not pass the output value");

  chk_latch_hold: assert property (
    (drv_mode == POTC_PATH_LATCH && drive_latch_gate) ##1
    (drv_mode == POTC_PATH_LATCH && !drive_latch_gate)
    |=> (pad_o == $past(out_val, 2)))
    else $error("latched drive value not held after gate closed");

  chk_enable_gate: assert property (
    (rise_a && !drive_reg_en && !flop_preset_clear && !chip_wide_init)
    |=> $stable(reg_a[`POTC_DRV_IDX]))
    else $error("drive register loaded while disabled");

  chk_sync_clear: assert property (
    (!DRV_SR_ASYNC && rise_a && flop_preset_clear && !chip_wide_init)
    |=> (reg_a[`POTC_DRV_IDX] == DRV_SR_SET))
    else $error("synchronous clear missed at clock a edge");

  chk_async_clear: assert property (
    (flop_preset_clear && !chip_wide_init)
    |=> (!DRV_SR_ASYNC || reg_b[`POTC_DRV_IDX] == DRV_SR_SET) &&
        (!HIZ_SR_ASYNC || reg_b[`POTC_HIZ_IDX] == HIZ_SR_SET))
    else $error("asynchronous clear waited for an output clock edge");

  chk_chip_init: assert property (
    chip_wide_init |=> (reg_a[`POTC_DRV_IDX] == DRV_SR_SET) &&
                       (reg_a[`POTC_HIZ_IDX] == HIZ_SR_SET))
    else $error("chip-wide init did not force registers");

  chk_ddr_pad_b: assert property (
    (drv_mode == POTC_PATH_DDR && rise_b && drive_reg_en && !flop_preset_clear &&
     !chip_wide_init) ##1
    (drv_mode == POTC_PATH_DDR && !rise_a && !chip_wide_init && !flop_preset_clear)
    |=> (pad_o == $past(ddr_val_b, 2)))
    else $error("pad does not show register b after clock b capture");

  chk_float_wins: assert property (
    chip_wide_float |=> !pad_oe)
    else $error("chip-wide float did not release the pad");

  chk_hiz_direct: assert property (
    (hiz_mode == POTC_PATH_DIRECT && !chip_wide_float) |=> (pad_oe == !$past(hiz_req)))
    else $error("direct hiz request not reflected on pad enable");

  chk_hiz_load: assert property (
    (hiz_mode == POTC_PATH_SDR && rise_a && hiz_reg_en && hiz_req &&
     !flop_preset_clear && !chip_wide_init) ##1
    (hiz_mode == POTC_PATH_SDR && !chip_wide_init && !flop_preset_clear)
    |=> !pad_oe)
    else $error("registered hiz request did not float the pad");

  chk_ddr_pad_a: assert property (
    (drv_mode == POTC_PATH_DDR && rise_a && drive_reg_en && !flop_preset_clear &&
     !chip_wide_init) ##1
    (drv_mode == POTC_PATH_DDR && !rise_b && !chip_wide_init && !flop_preset_clear)
    |=> (pad_o == $past(ddr_val_a, 2)))
    else $error("pad does not show register a after clock a capture");

  chk_ddr_clear_b: assert property (
    (!DRV_SR_ASYNC && rise_b && flop_preset_clear && !chip_wide_init)
    |=> (reg_b[`POTC_DRV_IDX] == DRV_SR_SET))
    else $error("synchronous clear missed at clock b edge");

  chk_hiz_enable: assert property (
    (rise_a && !hiz_reg_en && !flop_preset_clear && !chip_wide_init)
    |=> $stable(reg_a[`POTC_HIZ_IDX]))
    else $error("hiz register loaded while disabled");

  chk_hiz_latch: assert property (
    (hiz_mode == POTC_PATH_LATCH && hiz_latch_gate) ##1
    (hiz_mode == POTC_PATH_LATCH && !chip_wide_float)
    |=> (pad_oe == !$past(hiz_req, 2)))
    else $error("latched hiz request not reflected on pad enable");

endmodule : potc_pad_cell
`default_nettype wire

// ==== verification/potc_fabric_model.sv ====
// Fabric-side model that makes the two drive clocks for the pad cell
`timescale 1ns/10ps
`default_nettype none
module potc_fabric_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic drive_clk_a,
  output logic drive_clk_b,
  output logic [2:0] phase
);
  // ----------------------------------------------------------------------
  // Clock phase
  // ----------------------------------------------------------------------
  // Clocks stand still while not running; phase is published so the
  // driver changes shared enables only between the two rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
    end else if (run) begin
      phase <= phase + 3'h1;
    end
  end
  // Clock b is the inverse of a, so captures fall half a period apart
  assign drive_clk_a = phase[2];
  assign drive_clk_b = ~phase[2];
endmodule : potc_fabric_model
`default_nettype wire

// ==== verification/test_potc_pad_cell.sv ====
// Self-checking testbench of the pad output and tristate cell
`timescale 1ns/10ps
`default_nettype none
`include "potc_consts.svh"
module test_potc_pad_cell;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic drive_clk_a, drive_clk_b, out_val, ddr_val_a, ddr_val_b, drive_latch_gate;
  logic drive_reg_en, hiz_req, hiz_req_a, hiz_req_b, hiz_latch_gate, hiz_reg_en;
  logic flop_preset_clear, chip_wide_init, chip_wide_float, pad_o, pad_oe;
  logic ma, mb, mha, mhb, pad_o_as, pad_oe_as;
  logic [2:0] phase;
  logic [7:0] rnd;
  int fails, checks;
  // Set value 1 on drive, 0 on hiz so a clear returns the pad to driven data
  localparam logic DRV_SET = 1'b1;
  localparam logic HIZ_SET = 1'b0;
  // Second instance: asynchronous clears, and a hiz set value that floats the pad
  localparam logic HIZ_AS_SET = 1'b1;

  potc_pad_cell #(.DRV_SR_SET(DRV_SET), .DRV_SR_ASYNC(1'b0), .HIZ_SR_SET(HIZ_SET),
    .HIZ_SR_ASYNC(1'b0)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_clk_a(drive_clk_a), .drive_clk_b(drive_clk_b),
    .out_val(out_val), .ddr_val_a(ddr_val_a), .ddr_val_b(ddr_val_b),
    .drive_latch_gate(drive_latch_gate), .drive_reg_en(drive_reg_en), .hiz_req(hiz_req),
    .hiz_req_a(hiz_req_a), .hiz_req_b(hiz_req_b), .hiz_latch_gate(hiz_latch_gate),
    .hiz_reg_en(hiz_reg_en), .flop_preset_clear(flop_preset_clear),
    .chip_wide_init(chip_wide_init), .chip_wide_float(chip_wide_float), .pad_o(pad_o),
    .pad_oe(pad_oe));
  potc_pad_cell #(.DRV_SR_SET(DRV_SET), .DRV_SR_ASYNC(1'b1), .HIZ_SR_SET(HIZ_AS_SET),
    .HIZ_SR_ASYNC(1'b1)) i_dut_async (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .drive_clk_a(drive_clk_a), .drive_clk_b(drive_clk_b),
    .out_val(out_val), .ddr_val_a(ddr_val_a), .ddr_val_b(ddr_val_b),
    .drive_latch_gate(drive_latch_gate), .drive_reg_en(drive_reg_en), .hiz_req(hiz_req),
    .hiz_req_a(hiz_req_a), .hiz_req_b(hiz_req_b), .hiz_latch_gate(hiz_latch_gate),
    .hiz_reg_en(hiz_reg_en), .flop_preset_clear(flop_preset_clear),
    .chip_wide_init(chip_wide_init), .chip_wide_float(chip_wide_float), .pad_o(pad_o_as),
    .pad_oe(pad_oe_as));
  potc_fabric_model i_fab (.pclk(pclk), .presetn(presetn), .run(run),
    .drive_clk_a(drive_clk_a), .drive_clk_b(drive_clk_b), .phase(phase));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic exp_oe(input logic hz, input logic flt);
    return !hz && !flt;
  endfunction : exp_oe
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) fails++;
  endtask : apb
  task automatic wait_ph(input logic [2:0] v);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (phase !== v && n < 20);
    if (n >= 20) fails++;
  endtask : wait_ph
  task automatic sdr_step(input logic en, ov, hz, clr, eo, eoe);
    @(posedge pclk);
    drive_reg_en <= en; hiz_reg_en <= en; out_val <= ov; hiz_req <= hz;
    flop_preset_clear <= clr;
    wait_ph(3'h7);
    chk(pad_o, eo, "sdr data");
    chk(pad_oe, eoe, "sdr enable");
  endtask : sdr_step
  task automatic ddr_step(input logic en, va, vb, ha, hb, clr);
    wait_ph(3'h5);
    @(posedge pclk);
    drive_reg_en <= en; hiz_reg_en <= en; ddr_val_a <= va; ddr_val_b <= vb;
    hiz_req_a <= ha; hiz_req_b <= hb; flop_preset_clear <= clr;
    if (clr) begin
      ma = DRV_SET; mb = DRV_SET; mha = HIZ_SET; mhb = HIZ_SET;
    end else if (en) begin
      ma = va; mb = vb; mha = ha; mhb = hb;
    end
    wait_ph(3'h3);
    chk({pad_o, pad_oe}, {mb, !mhb}, "ddr reg b");
    wait_ph(3'h7);
    chk({pad_o, pad_oe}, {ma, !mha}, "ddr reg a");
  endtask : ddr_step
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #(5000 * 40);
    fails++;
    give_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, run, out_val, ddr_val_a, ddr_val_b} = 8'h00;
    {drive_latch_gate, drive_reg_en, hiz_req, hiz_req_a, hiz_req_b} = 5'h00;
    {hiz_latch_gate, hiz_reg_en, flop_preset_clear, chip_wide_init, chip_wide_float} = 5'h00;
    paddr = 12'h000; pwdata = 32'h0000_0000; rnd = 8'h12;
    {ma, mb, mha, mhb} = 4'h0;
    fails = 0; checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `POTC_CTRL_ADDR, 32'h0);
    chk(rd, `POTC_CTRL_RST, "ctrl reset");
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped access");
    // Direct paths, random data, request and chip-wide float
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      @(posedge pclk);
      out_val <= rnd[0]; hiz_req <= rnd[1]; chip_wide_float <= rnd[2] & rnd[3];
      repeat (3) @(negedge pclk);
      chk(pad_oe, exp_oe(rnd[1], rnd[2] & rnd[3]), "direct enable");
      if (exp_oe(rnd[1], rnd[2] & rnd[3])) chk(pad_o, rnd[0], "direct data");
    end
    // Latch paths: transparent, then holding
    apb(1'b1, `POTC_CTRL_ADDR, 32'h5);
    @(posedge pclk);
    chip_wide_float <= 1'b0; drive_latch_gate <= 1'b1; hiz_latch_gate <= 1'b1;
    out_val <= 1'b1; hiz_req <= 1'b0;
    repeat (3) @(negedge pclk);
    chk({pad_o, pad_oe}, 2'b11, "latch open");
    @(posedge pclk);
    drive_latch_gate <= 1'b0; hiz_latch_gate <= 1'b0; out_val <= 1'b0; hiz_req <= 1'b1;
    repeat (3) @(negedge pclk);
    chk({pad_o, pad_oe}, 2'b11, "latch closed");
    @(posedge pclk);
    hiz_latch_gate <= 1'b1;
    repeat (3) @(negedge pclk);
    chk(pad_oe, 1'b0, "latch float");
    // Single-rate registers
    apb(1'b1, `POTC_CTRL_ADDR, 32'hA);
    run <= 1'b1;
    sdr_step(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    sdr_step(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    sdr_step(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge pclk);
    drive_reg_en <= 1'b0; hiz_reg_en <= 1'b0; chip_wide_init <= 1'b1;
    @(posedge pclk);
    chip_wide_init <= 1'b0;
    repeat (3) @(negedge pclk);
    chk({pad_o, pad_oe}, {DRV_SET, !HIZ_SET}, "chip-wide init");
    sdr_step(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    sdr_step(1'b0, 1'b0, 1'b1, 1'b1, DRV_SET, !HIZ_SET);
    // Double-rate registers
    apb(1'b1, `POTC_CTRL_ADDR, 32'hF);
    ddr_step(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    ddr_step(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    ddr_step(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    ddr_step(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    ddr_step(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    // Clocks parked: only the asynchronous instance may react to a clear
    run <= 1'b0;
    chk({pad_o_as, pad_oe_as}, 2'b01, "async before clear");
    @(posedge pclk);
    flop_preset_clear <= 1'b1;
    @(posedge pclk);
    flop_preset_clear <= 1'b0;
    repeat (3) @(negedge pclk);
    chk({pad_o_as, pad_oe_as}, {DRV_SET, !HIZ_AS_SET}, "async clear");
    chk({pad_o, pad_oe}, 2'b01, "sync clear waits for edge");
    apb(1'b0, `POTC_STAT_ADDR, 32'h0);
    chk(rd, 32'h1 << `POTC_STAT_PAD_OE, "status word");
    give_verdict();
  end
endmodule : test_potc_pad_cell
`default_nettype wire
